// ---- verilog/uart_stat_pkg.sv ----
// Shared constants and types for the serial status and sampling block
package uart_stat_pkg;

  // ==========================================================
  // Register word indices (byte address = index * 4)
  localparam logic [5:0] TX_BUF_IDX = 6'h00;
  localparam logic [5:0] RX_BUF_IDX = 6'h02;
  localparam logic [5:0] INT_CTRL_IDX = 6'h04;
  localparam logic [5:0] STATUS_IDX = 6'h06;
  localparam logic [5:0] FRAME_SEL_IDX = 6'h08;
  localparam logic [5:0] MODE_SEL_IDX = 6'h0a;
  localparam logic [5:0] DIV_LOW_IDX = 6'h0c;
  localparam logic [5:0] PRESCALE_IDX = 6'h0e;
  localparam logic [5:0] OVS_RATE_IDX = 6'h10;
  localparam logic [5:0] SMP_MODE_IDX = 6'h12;
  localparam logic [5:0] SMP_POS_IDX = 6'h14;

  // ==========================================================
  // Reset values
  localparam logic [7:0] INT_CTRL_RST = 8'h01;
  localparam logic [3:0] SMP_POS_RST = 4'h6;
  localparam logic [3:0] OVS_RATE_RST = 4'h0;

  // ==========================================================
  // Field positions
  localparam int FRS_STOP_BIT = 2;
  localparam int FRS_TX9_BIT = 3;
  localparam int FRS_PSEL_LSB = 4;
  localparam int FRS_PEN_BIT = 6;
  localparam int MODE_BRK_BIT = 2;
  localparam int MODE_ETD_BIT = 4;
  localparam int MODE_ERD_BIT = 5;
  localparam int MODE_RTS_BIT = 7;
  localparam int ICTRL_EEI_BIT = 7;
  localparam int ICTRL_ERI_BIT = 6;
  localparam int ICTRL_ETI_BIT = 5;
  localparam int ICTRL_EFCI_BIT = 4;

  // ==========================================================
  // Sampling and framing counts
  localparam logic [3:0] OVS_MIN_CODE = 4'h7;
  localparam logic [4:0] OVS_DEFAULT_RATE = 5'h10;
  localparam logic [4:0] SAMPLE_SPAN = 5'h3;
  localparam logic [3:0] BREAK_BITS = 4'ha;

  typedef enum logic [1:0] {
    FMT_8 = 2'b00,
    FMT_7 = 2'b01,
    FMT_9 = 2'b10,
    FMT_LOOP = 2'b11
  } char_fmt_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b011,
    RX_STOP = 3'b010,
    RX_BREAK = 3'b110
  } rx_state_t;

endpackage : uart_stat_pkg

// ---- verilog/baud_tick_gen.sv ----
// Two-stage divider: half-step prescaler then baud divisor, one pulse per oversample period
`timescale 1ns/1ps
module baud_tick_gen import uart_stat_pkg::*; #(
  parameter int DIV_W = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] prescale_code,
  input wire logic [DIV_W-1:0] baud_divisor,
  output logic os_tick
);

  typedef struct packed {
    logic [5:0] acc;
    logic [DIV_W-1:0] cnt;
    logic tick;
  } gen_t;

  gen_t st_ff;
  gen_t nxt;
  logic [5:0] modulus;
  logic [5:0] acc_sum;
  logic pre_tick;

  // Prescale factor is (code+2)/2, so half steps need no second clock
  assign modulus = {1'b0, prescale_code} + 6'h2;
  assign acc_sum = st_ff.acc + 6'h2;
  assign pre_tick = acc_sum >= modulus;

  always_comb begin
    nxt = st_ff;
    nxt.tick = 1'b0;
    nxt.acc = pre_tick ? 6'(acc_sum - modulus) : acc_sum;
    if (pre_tick) begin
      if (st_ff.cnt >= baud_divisor) begin
        nxt.cnt = '0;
        nxt.tick = 1'b1;
      end else begin
        nxt.cnt = st_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt;
    end
  end

  assign os_tick = st_ff.tick;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  tick_spacing_a: assert property (
    os_tick && baud_divisor != '0 && $stable(baud_divisor) |=> !os_tick)
    else $error("oversample ticks closer than the divisor allows");

endmodule : baud_tick_gen

// ---- verilog/uart_status_irq_oversampling.sv ----
// Serial status flags, interrupt control and oversampled receive/transmit engine behind APB
// Function
// - Status register read-only, cleared by reset
// - Parity error sets, clears on status read
// - Missing stop bit sets framing error
// - Overrun on unread buffer, cleared by read
// - Error summary is OR of three flags
// - Break after ten low bit times
// - Break clears on read only when ended
// - Ninth received bit captured in 9-bit mode
// - Transmit-in-progress high until last frame ends
// - Interrupt control mixed access, resets 01h
// - Buffer empty on load, cleared by write
// - Receive full on transfer, cleared by read
// - Clear-to-send change flag, first instance only
// - Flow interrupt on delta flag when enabled
// - Transmit interrupt on empty when enabled
// - Receive interrupt on full when enabled
// - Error interrupt on summary when enabled
// - Oversample codes 0-6 give 16, else code
// - Sample mode bit picks auto or programmed
// - Three samples from programmed period, reset 06h
// - Auto first sample at (rate-3)/2
// - Bit rate is clock over O*N*P
// - Eleven-bit divisor, divide by value plus one
// - Format 00=8, 01=7, 10=9, 11=loop 9
// - Receive DMA masks receive-full interrupt only
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module uart_status_irq_oversampling import uart_stat_pkg::*; #(
  parameter bit FIRST_UART_INSTANCE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  output logic rts_n,
  output logic irq
);

  typedef struct packed {
    logic [7:0] rx_buf;
    logic [7:0] tx_buf;
    logic [7:0] frame_sel;
    logic [7:0] mode_sel;
    logic [7:0] div_low;
    logic [7:0] prescale;
    logic [3:0] oversample_field;
    logic [3:0] first_sample_period;
    logic manual_sample_mode;
    logic [3:0] irq_enables;
    logic delta_clear_to_send;
    logic receive_buffer_full;
    logic transmit_buffer_empty;
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_flag;
    logic break_detect_flag;
    logic break_read_seen;
    logic received_ninth_bit;
    logic transmit_in_progress;
    logic [2:0] rx_sync;
    logic [2:0] cts_sync;
    logic rx_filt;
    logic cts_filt;
    rx_state_t rx_st;
    logic [3:0] rx_os;
    logic [1:0] votes;
    logic [3:0] rx_cnt;
    logic [9:0] rx_sh;
    logic [3:0] tx_os;
    logic [3:0] tx_cnt;
    logic [11:0] tx_sh;
    logic txd;
    logic irq;
    logic rd_done;
    logic [7:0] rdat;
  } state_t;

  state_t st_ff;
  state_t nxt;

  // ==========================================================
  // Bus decode
  logic [5:0] idx;
  logic hit;
  logic acc_rd;
  logic acc_wr;
  logic rd_edge;
  logic status_rd;
  logic ictrl_rd;
  logic rxbuf_rd;
  logic txbuf_wr;

  assign idx = paddr[7:2];
  assign hit = (paddr[1:0] == 2'b00) && (idx <= SMP_POS_IDX) && !idx[0];
  assign acc_rd = psel && penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;
  // Reads take one wait state so read side effects and data land together
  assign rd_edge = acc_rd && !st_ff.rd_done;
  assign status_rd = rd_edge && hit && idx == STATUS_IDX;
  assign ictrl_rd = rd_edge && hit && idx == INT_CTRL_IDX;
  assign rxbuf_rd = rd_edge && hit && idx == RX_BUF_IDX;
  assign txbuf_wr = acc_wr && hit && idx == TX_BUF_IDX;
  assign pready = !acc_rd || st_ff.rd_done;
  assign pslverr = psel && penable && pready && !hit;
  assign prdata = {24'h000000, st_ff.rdat};

  // ==========================================================
  // Frame format and sampling geometry
  char_fmt_t fmt;
  logic nine;
  logic has_par;
  logic [3:0] nd;
  logic [3:0] nb;
  logic [4:0] rate;
  logic [3:0] last;
  logic [3:0] pos;
  logic rx_in;
  logic os_tick;
  logic err_sum;

  assign fmt = char_fmt_t'(st_ff.frame_sel[1:0]);
  assign nine = fmt == FMT_9 || fmt == FMT_LOOP;
  assign has_par = st_ff.frame_sel[FRS_PEN_BIT] && !nine;
  assign nd = (fmt == FMT_7) ? 4'h7 : (nine ? 4'h9 : 4'h8);
  assign nb = nd + {3'b000, has_par};
  assign rate = (st_ff.oversample_field < OVS_MIN_CODE) ? OVS_DEFAULT_RATE
    : {1'b0, st_ff.oversample_field};
  assign last = 4'(rate - 5'h1);
  assign pos = st_ff.manual_sample_mode ? st_ff.first_sample_period
    : 4'((rate - SAMPLE_SPAN) >> 1);
  // Loop-back feeds the transmitter straight in, no synchroniser needed
  assign rx_in = (fmt == FMT_LOOP) ? st_ff.txd : st_ff.rx_filt;
  assign err_sum = st_ff.parity_error_flag | st_ff.framing_error_flag | st_ff.overrun_flag;

  baud_tick_gen #(
    .DIV_W(11)
  ) u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .prescale_code(st_ff.prescale[7:3]),
    .baud_divisor({st_ff.prescale[2:0], st_ff.div_low}),
    .os_tick(os_tick)
  );

  function automatic logic par_of(input logic [1:0] sel, input logic [7:0] d);
    case (sel)
      2'b00: par_of = ~^d;
      2'b01: par_of = ^d;
      2'b10: par_of = 1'b1;
      default: par_of = 1'b0;
    endcase
  endfunction : par_of

  // ==========================================================
  // Next-state logic
  logic rx_done;
  logic rx_perr;
  logic rx_ferr;
  logic break_hit;
  logic tx_load;
  logic [9:0] aligned;
  logic [7:0] rx_data;
  logic [7:0] tx_data;
  logic [9:0] payload;
  logic [10:0] frame;
  logic bit_end;
  logic bit_val;
  logic [4:0] os_wide;
  logic in_win;
  logic [1:0] vote_sum;

  always_comb begin
    nxt = st_ff;
    rx_done = 1'b0;
    rx_perr = 1'b0;
    rx_ferr = 1'b0;
    break_hit = 1'b0;
    tx_load = 1'b0;
    aligned = st_ff.rx_sh >> (4'ha - nb);
    rx_data = aligned[7:0] & ((fmt == FMT_7) ? 8'h7f : 8'hff);
    tx_data = st_ff.tx_buf & ((fmt == FMT_7) ? 8'h7f : 8'hff);
    payload = {2'b00, tx_data};
    if (nine) begin
      payload[8] = st_ff.frame_sel[FRS_TX9_BIT];
    end
    if (has_par) begin
      payload[nd] = par_of(st_ff.frame_sel[FRS_PSEL_LSB +: 2], tx_data);
    end
    frame = (11'h7ff << nb) | {1'b0, payload};
    bit_end = os_tick && st_ff.rx_os == last;
    os_wide = {1'b0, st_ff.rx_os};
    // Third vote may land on the bit's last period, so count it before deciding
    in_win = os_tick && os_wide >= {1'b0, pos} && os_wide <= {1'b0, pos} + 5'h2;
    vote_sum = st_ff.votes + {1'b0, in_win && rx_in};
    bit_val = vote_sum[1];

    // Pin synchronisers: a change counts once stages two and three agree
    nxt.rx_sync = {st_ff.rx_sync[1:0], rxd};
    nxt.cts_sync = {st_ff.cts_sync[1:0], cts_n};
    if (st_ff.rx_sync[2] == st_ff.rx_sync[1]) begin
      nxt.rx_filt = st_ff.rx_sync[2];
    end
    if (st_ff.cts_sync[2] == st_ff.cts_sync[1]) begin
      nxt.cts_filt = st_ff.cts_sync[2];
    end

    // Receiver: three votes per bit, majority at end of bit
    if (os_tick && st_ff.rx_st != RX_IDLE) begin
      nxt.rx_os = (st_ff.rx_os == last) ? 4'h0 : st_ff.rx_os + 4'h1;
      nxt.votes = vote_sum;
      if (bit_end) begin
        nxt.votes = 2'b00;
      end
    end
    case (st_ff.rx_st)
      RX_IDLE: begin
        if (os_tick && !rx_in) begin
          nxt.rx_st = RX_START;
          nxt.rx_os = 4'h1;
          nxt.votes = 2'b00;
        end
      end
      RX_START: begin
        if (bit_end) begin
          nxt.rx_st = bit_val ? RX_IDLE : RX_DATA;
          nxt.rx_cnt = 4'h0;
        end
      end
      RX_DATA: begin
        if (bit_end) begin
          nxt.rx_sh = {bit_val, st_ff.rx_sh[9:1]};
          nxt.rx_cnt = st_ff.rx_cnt + 4'h1;
          if (st_ff.rx_cnt + 4'h1 == nb) begin
            nxt.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (bit_end) begin
          rx_done = 1'b1;
          rx_ferr = !bit_val;
          rx_perr = has_par && aligned[nd] != par_of(st_ff.frame_sel[FRS_PSEL_LSB +: 2], rx_data);
          nxt.rx_buf = rx_data;
          if (nine) begin
            nxt.received_ninth_bit = aligned[8];
          end
          nxt.rx_st = bit_val ? RX_IDLE : RX_BREAK;
          nxt.rx_cnt = 4'h0;
        end
      end
      RX_BREAK: begin
        if (bit_end) begin
          if (bit_val) begin
            nxt.rx_st = RX_IDLE;
          end else if (st_ff.rx_cnt != BREAK_BITS) begin
            nxt.rx_cnt = st_ff.rx_cnt + 4'h1;
            break_hit = st_ff.rx_cnt + 4'h1 == BREAK_BITS;
          end
        end
      end
      default: begin
        nxt.rx_st = RX_IDLE;
      end
    endcase

    // Receive flags: a hardware set wins over a software clear
    if (rx_done) begin
      nxt.receive_buffer_full = 1'b1;
    end else if (rxbuf_rd) begin
      nxt.receive_buffer_full = 1'b0;
    end
    if (rx_done && rx_perr) begin
      nxt.parity_error_flag = 1'b1;
    end else if (status_rd) begin
      nxt.parity_error_flag = 1'b0;
    end
    if (rx_done && rx_ferr) begin
      nxt.framing_error_flag = 1'b1;
    end else if (status_rd) begin
      nxt.framing_error_flag = 1'b0;
    end
    if (rx_done && st_ff.receive_buffer_full && !rxbuf_rd) begin
      nxt.overrun_flag = 1'b1;
    end else if (status_rd) begin
      nxt.overrun_flag = 1'b0;
    end
    if (break_hit) begin
      nxt.break_detect_flag = 1'b1;
    end else if (rx_in && (status_rd || st_ff.break_read_seen)) begin
      nxt.break_detect_flag = 1'b0;
    end
    nxt.break_read_seen = nxt.break_detect_flag && (st_ff.break_read_seen || status_rd);

    // Clear-to-send change tracking
    if (FIRST_UART_INSTANCE && nxt.cts_filt != st_ff.cts_filt) begin
      nxt.delta_clear_to_send = 1'b1;
    end else if (ictrl_rd) begin
      nxt.delta_clear_to_send = 1'b0;
    end

    // Transmitter: holding byte moves to shift register when it is free
    if (st_ff.tx_cnt == 4'h0 && !st_ff.transmit_buffer_empty) begin
      tx_load = 1'b1;
      nxt.tx_sh = {frame, 1'b0};
      nxt.tx_cnt = 4'h2 + nb + {3'b000, st_ff.frame_sel[FRS_STOP_BIT]};
      nxt.tx_os = 4'h0;
      nxt.transmit_in_progress = 1'b1;
    end else if (os_tick && st_ff.tx_cnt != 4'h0) begin
      if (st_ff.tx_os == last) begin
        nxt.tx_os = 4'h0;
        nxt.tx_sh = {1'b1, st_ff.tx_sh[11:1]};
        nxt.tx_cnt = st_ff.tx_cnt - 4'h1;
        // Stays high across back-to-back frames
        if (st_ff.tx_cnt == 4'h1 && st_ff.transmit_buffer_empty) begin
          nxt.transmit_in_progress = 1'b0;
        end
      end else begin
        nxt.tx_os = st_ff.tx_os + 4'h1;
      end
    end
    nxt.txd = st_ff.tx_sh[0] && !st_ff.mode_sel[MODE_BRK_BIT];
    if (tx_load) begin
      nxt.transmit_buffer_empty = 1'b1;
    end else if (txbuf_wr) begin
      nxt.transmit_buffer_empty = 1'b0;
    end

    // Register writes; status and flag bits ignore writes
    if (acc_wr && hit) begin
      case (idx)
        TX_BUF_IDX: nxt.tx_buf = pwdata[7:0];
        FRAME_SEL_IDX: nxt.frame_sel = {1'b0, pwdata[6:0]};
        MODE_SEL_IDX: nxt.mode_sel = pwdata[7:0];
        DIV_LOW_IDX: nxt.div_low = pwdata[7:0];
        PRESCALE_IDX: nxt.prescale = pwdata[7:0];
        OVS_RATE_IDX: nxt.oversample_field = pwdata[3:0];
        SMP_MODE_IDX: nxt.manual_sample_mode = pwdata[0];
        SMP_POS_IDX: nxt.first_sample_period = pwdata[3:0];
        INT_CTRL_IDX: nxt.irq_enables = pwdata[7:4];
        default: nxt.div_low = st_ff.div_low;
      endcase
    end

    // Read data captured on the first access cycle
    nxt.rd_done = rd_edge;
    if (rd_edge) begin
      case (idx)
        RX_BUF_IDX: nxt.rdat = st_ff.rx_buf;
        TX_BUF_IDX: nxt.rdat = st_ff.tx_buf;
        INT_CTRL_IDX: nxt.rdat = {st_ff.irq_enables, ~st_ff.cts_filt & FIRST_UART_INSTANCE,
          st_ff.delta_clear_to_send, st_ff.receive_buffer_full, st_ff.transmit_buffer_empty};
        STATUS_IDX: nxt.rdat = {1'b0, st_ff.transmit_in_progress, st_ff.received_ninth_bit,
          st_ff.break_detect_flag, err_sum, st_ff.overrun_flag, st_ff.framing_error_flag,
          st_ff.parity_error_flag};
        FRAME_SEL_IDX: nxt.rdat = st_ff.frame_sel;
        MODE_SEL_IDX: nxt.rdat = st_ff.mode_sel;
        DIV_LOW_IDX: nxt.rdat = st_ff.div_low;
        PRESCALE_IDX: nxt.rdat = st_ff.prescale;
        OVS_RATE_IDX: nxt.rdat = {4'h0, st_ff.oversample_field};
        SMP_MODE_IDX: nxt.rdat = {7'h00, st_ff.manual_sample_mode};
        SMP_POS_IDX: nxt.rdat = {4'h0, st_ff.first_sample_period};
        default: nxt.rdat = 8'h00;
      endcase
    end

    // Level request; receive DMA hides only the buffer-full source
    nxt.irq = (st_ff.transmit_buffer_empty && st_ff.irq_enables[ICTRL_ETI_BIT - 4]
      && !st_ff.mode_sel[MODE_ETD_BIT])
      || (st_ff.receive_buffer_full && st_ff.irq_enables[ICTRL_ERI_BIT - 4]
      && !st_ff.mode_sel[MODE_ERD_BIT])
      || (err_sum && st_ff.irq_enables[ICTRL_EEI_BIT - 4])
      || (st_ff.delta_clear_to_send && st_ff.irq_enables[ICTRL_EFCI_BIT - 4]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.transmit_buffer_empty <= INT_CTRL_RST[0];
      st_ff.first_sample_period <= SMP_POS_RST;
      st_ff.oversample_field <= OVS_RATE_RST;
      st_ff.rx_sync <= 3'b111;
      st_ff.cts_sync <= 3'b111;
      st_ff.rx_filt <= 1'b1;
      st_ff.cts_filt <= 1'b1;
      st_ff.tx_sh <= 12'hfff;
      st_ff.txd <= 1'b1;
    end else begin
      st_ff <= nxt;
    end
  end

  assign txd = st_ff.txd;
  assign rts_n = !st_ff.mode_sel[MODE_RTS_BIT];
  assign irq = st_ff.irq;

  // ==========================================================
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence status_read_s;
    status_rd && !rx_done;
  endsequence

  sequence frame_end_s;
    rx_done ##1 1'b1;
  endsequence

  parity_clear_a: assert property (status_read_s |=> !st_ff.parity_error_flag)
    else $error("parity flag survived status read");
  framing_set_a: assert property (rx_done && rx_ferr |=> st_ff.framing_error_flag)
    else $error("framing flag not set on bad stop bit");
  overrun_set_a: assert property (
    rx_done && st_ff.receive_buffer_full && !rxbuf_rd |=> st_ff.overrun_flag)
    else $error("overrun not flagged");
  summary_read_a: assert property (status_rd |=> st_ff.rdat[3] == |st_ff.rdat[2:0])
    else $error("error summary disagrees with error flags");
  break_clear_a: assert property (st_ff.break_detect_flag && rx_in && status_rd |=> !st_ff.break_detect_flag)
    else $error("break flag not cleared after break ended");
  empty_clear_a: assert property (txbuf_wr && !tx_load |=> !st_ff.transmit_buffer_empty)
    else $error("buffer empty flag not cleared by write");
  full_set_a: assert property (frame_end_s |-> st_ff.receive_buffer_full)
    else $error("receive full flag not set after frame");
  cts_delta_a: assert property (st_ff.cts_filt != $past(st_ff.cts_filt) |-> ##[0:1] st_ff.delta_clear_to_send)
    else $error("clear-to-send change not flagged");
  level_irq_a: assert property (
    (st_ff.receive_buffer_full && st_ff.irq_enables[2] && !st_ff.mode_sel[MODE_ERD_BIT])
      [*2] |-> irq)
    else $error("interrupt dropped while enabled flag set");
  dma_mask_a: assert property (
    st_ff.mode_sel[MODE_ERD_BIT] && !err_sum && !st_ff.delta_clear_to_send && !st_ff.transmit_buffer_empty
      ##1 $stable(st_ff.mode_sel) && $stable(st_ff.irq_enables) |-> !irq)
    else $error("receive interrupt leaked through with DMA enabled");
  rate_range_a: assert property (rate >= 5'h7 && rate <= 5'h10)
    else $error("oversample rate outside 7 to 16");
  xmip_hold_a: assert property (st_ff.tx_cnt != 4'h0 |-> st_ff.transmit_in_progress)
    else $error("transmit in progress low during frame");

endmodule : uart_status_irq_oversampling

// ---- bench/serial_peer.sv ----
// Remote serial peer: sends frames on the receive line, drives clear-to-send
`timescale 1ns/1ps
module serial_peer (
  input wire logic pclk,
  output logic rxd,
  output logic cts_n
);
  initial begin
    rxd = 1'b1;
    cts_n = 1'b1;
  end

  // ==========================================================
  // Frame: start, nb bits LSB first, stop level, then 1+lowb more bit times held at the stop level
  // Line is left at the stop level; a bad stop keeps it low until idle
  task automatic send(input logic [9:0] d, input int nb, input int bclk, input logic stp, input int lowb);
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge pclk);
      rxd <= (i == 0) ? 1'b0 : (i == nb + 1) ? stp : d[i-1];
      repeat (bclk - 1) @(posedge pclk);
    end
    repeat (bclk + lowb * bclk) @(posedge pclk);
  endtask : send

  task automatic idle();
    @(posedge pclk);
    rxd <= 1'b1;
  endtask : idle

  task automatic set_cts(input logic v);
    @(posedge pclk);
    cts_n <= v;
  endtask : set_cts
endmodule : serial_peer

// ---- bench/testbench.sv ----
// Self-checking bench for the serial status and sampling block
`timescale 1ns/1ps
module testbench import uart_stat_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] seed = 32'h9876981d;
  logic pready, pslverr, txd, rts_n, irq, rxd, cts_n, slv;
  logic [7:0] rd;
  int err_total = 0;
  int n_checks = 0;
  int oc, bc;

  always #10 pclk = ~pclk;

  uart_status_irq_oversampling dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
  serial_peer peer_u (.pclk(pclk), .rxd(rxd), .cts_n(cts_n));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic int ovs_rate(input int code);
    return (code < 7) ? 16 : code;
  endfunction : ovs_rate

  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a stalled transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rdchk

  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask : settle

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    $display("ERROR t=%0t watchdog expired", $time);
    final_report();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(INT_CTRL_IDX, INT_CTRL_RST);
    rdchk(STATUS_IDX, 8'h00);
    rdchk(SMP_POS_IDX, 8'h06);
    rdchk(OVS_RATE_IDX, 8'h00);
    apb(1'b1, STATUS_IDX, 8'h7f);
    rdchk(STATUS_IDX, 8'h00);
    apb(1'b1, INT_CTRL_IDX, 8'hff);
    rdchk(INT_CTRL_IDX, 8'hf1);
    chk({7'h0, irq}, 8'h01);
    rdchk(6'h3f, 8'h00);
    chk({7'h0, slv}, 8'h01);
    apb(1'b1, INT_CTRL_IDX, 8'h00);
    apb(1'b1, FRAME_SEL_IDX, 8'h50);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr_next(seed);
      oc = (k == 3) ? seed[2:0] % 7 : 7 + seed[7:0] % 9;
      bc = ovs_rate(oc);
      apb(1'b1, OVS_RATE_IDX, 8'(oc));
      apb(1'b1, SMP_MODE_IDX, {7'h0, k[0]});
      apb(1'b1, SMP_POS_IDX, 8'(bc - 3));
      // Divisor 1 with half-step prescale 1.5 gives three clocks per sample
      apb(1'b1, DIV_LOW_IDX, {7'h0, k == 2});
      apb(1'b1, PRESCALE_IDX, {4'h0, k == 2, 3'h0});
      peer_u.send({1'b0, ^seed[15:8], seed[15:8]}, 9, (k == 2) ? 3 * bc : bc, 1'b1, 0);
      settle();
      rdchk(INT_CTRL_IDX, 8'h03);
      rdchk(RX_BUF_IDX, seed[15:8]);
      rdchk(INT_CTRL_IDX, 8'h01);
    end
    apb(1'b1, INT_CTRL_IDX, 8'h80);
    peer_u.send({1'b0, ~^8'h5a, 8'h5a}, 9, bc, 1'b1, 0);
    settle();
    chk({7'h0, irq}, 8'h01);
    rdchk(STATUS_IDX, 8'h09);
    rdchk(STATUS_IDX, 8'h00);
    chk({7'h0, irq}, 8'h00);
    peer_u.send({1'b0, ^8'h3c, 8'h3c}, 9, bc, 1'b1, 0);
    settle();
    rdchk(STATUS_IDX, 8'h0c);
    rdchk(RX_BUF_IDX, 8'h3c);
    peer_u.send({1'b0, ^8'ha5, 8'ha5}, 9, bc, 1'b0, 11);
    rdchk(STATUS_IDX, 8'h1a);
    rdchk(STATUS_IDX, 8'h10);
    peer_u.idle();
    settle();
    rdchk(STATUS_IDX, 8'h00);
    // Let the receiver leave the break state before the next start bit
    repeat (2 * bc) @(posedge pclk);
    apb(1'b0, RX_BUF_IDX, 8'h00);
    apb(1'b1, FRAME_SEL_IDX, 8'h02);
    peer_u.send({2'b01, 8'h77}, 9, bc, 1'b1, 0);
    settle();
    rdchk(STATUS_IDX, 8'h20);
    rdchk(RX_BUF_IDX, 8'h77);
    apb(1'b1, INT_CTRL_IDX, 8'h40);
    peer_u.send({2'b00, 8'h11}, 9, bc, 1'b1, 0);
    settle();
    chk({7'h0, irq}, 8'h01);
    apb(1'b1, MODE_SEL_IDX, 8'ha0);
    settle();
    chk({7'h0, irq}, 8'h00);
    chk({7'h0, rts_n}, 8'h00);
    apb(1'b1, MODE_SEL_IDX, 8'h00);
    rdchk(RX_BUF_IDX, 8'h11);
    apb(1'b1, INT_CTRL_IDX, 8'h20);
    apb(1'b1, TX_BUF_IDX, 8'h96);
    apb(1'b0, STATUS_IDX, 8'h00);
    chk(rd & 8'h40, 8'h40);
    chk({7'h0, irq}, 8'h01);
    repeat (12 * bc + 10) @(posedge pclk);
    apb(1'b0, STATUS_IDX, 8'h00);
    chk(rd & 8'h40, 8'h00);
    chk({7'h0, txd}, 8'h01);
    // Loop-back with ninth bit set: the receiver checks what was sent
    apb(1'b1, FRAME_SEL_IDX, 8'h0b);
    apb(1'b1, TX_BUF_IDX, 8'hc3);
    repeat (12 * bc + 10) @(posedge pclk);
    rdchk(RX_BUF_IDX, 8'hc3);
    rdchk(STATUS_IDX, 8'h20);
    apb(1'b1, INT_CTRL_IDX, 8'h10);
    apb(1'b0, INT_CTRL_IDX, 8'h00);
    peer_u.set_cts(1'b0);
    settle();
    chk({7'h0, irq}, 8'h01);
    rdchk(INT_CTRL_IDX, 8'h1d);
    rdchk(INT_CTRL_IDX, 8'h19);
    chk({7'h0, irq}, 8'h00);
    final_report();
  end
endmodule : testbench
